/* hdl/rlcr_map.svh */
// register offsets, field positions and reset values of the lane configuration bank
`ifndef RLCR_MAP_SVH
`define RLCR_MAP_SVH

`define RLCR_OFS_EQ        8'h2C
`define RLCR_OFS_SWING     8'h2D
`define RLCR_OFS_DEEMPH    8'h2E
`define RLCR_OFS_IDLE      8'h2F
`define RLCR_OFS_SPARE     8'h30
`define RLCR_OFS_SDET      8'h31

`define RLCR_RST_EQ        8'h2F
`define RLCR_RST_SWING     8'hAD
`define RLCR_RST_DEEMPH    5'h02
`define RLCR_RST_IDLE      8'h00
`define RLCR_RST_SPARE     8'h00
`define RLCR_RST_SDET      8'h00

`define RLCR_BIT_SCP       7
`define RLCR_BIT_RATE_SEL  6
`define RLCR_BIT_RX_FOUND  7
`define RLCR_BIT_FORCE_OFF 2
`define RLCR_BIT_FORCE_ON  1
`define RLCR_DEEMPH_WMSB   4
`define RLCR_RATE_NONE     2'h0
`define RLCR_RDATA_NONE    8'h00

`endif

/* hdl/rlcr_pkg.sv */
// types shared by the lane configuration bank and its users
package rlcr_pkg;

  // settings that the lane analog datapath consumes
  typedef struct packed {
    logic [7:0] input_equalizer_level;
    logic       short_protect_en;
    logic       rate_class_low;
    logic [2:0] swing_spare;
    logic [2:0] output_swing_code;
    logic [2:0] deemphasis_code;
    logic [1:0] idle_assert_code;
    logic [1:0] idle_deassert_code;
  } rlcr_lane_ctrl_s;

  // status reported by the lane analog datapath
  typedef struct packed {
    logic       far_receiver_found;
    logic [1:0] detected_rate;
    logic       lane_a1_raw_detect;
  } rlcr_lane_stat_s;

endpackage

/* hdl/rlcr_lane_regs.sv */
// lane a0 configuration and status registers, plus lane a1 signal-detect forcing
//
// What this block does
// - lane a0 input equalizer level, 8-bit read/write, 256 levels, resets to 0x2F.
// - output swing register bit 7 enables short-circuit protection; register resets to 0xAD.
// - swing bit 6 selects rate class, 1 gen1/gen2, 0 gen3, overriding pin.
// - 3-bit output swing code, 0.7 V to 1.4 V in 0.1 V steps, default 101.
// - de-emphasis register bit 7 read-only, 1 when far receiver detected.
// - read-only bits 6:5 report detected rate: 00 gen1, 01 gen2, 11 gen3.
// - detected rate updates only while rate pin strapped automatic; otherwise no result.
// - de-emphasis code bits 2:0, 0 dB down to -12 dB, default 010.
// - idle assert threshold bits 3:2, codes for 180/160/210/190 mVp-p, default 00.
// - idle de-assert threshold bits 1:0, codes for 110/100/150/130 mVp-p, default 00.
// - programmed idle thresholds override the threshold select pin for this lane.
// - signal-detect bit 2 forces detect off, bit 1 forces on; clear restores.
`timescale 1ns/1ps
`default_nettype none
`include "rlcr_map.svh"

module rlcr_lane_regs
  import rlcr_pkg::*;
(
  input  wire logic            CLOCK,
  input  wire logic            RST_N,
  input  wire logic [7:0]      REG_ADDR,
  input  wire logic            REG_WR,
  input  wire logic [7:0]      REG_WDATA,
  input  wire logic            REG_RD,
  output logic      [7:0]      REG_RDATA,
  output logic                 REG_RVALID,
  input  wire rlcr_lane_stat_s LANE_STAT,
  input  wire logic            RATE_PIN_AUTO,
  output var  rlcr_lane_ctrl_s LANE_CTRL,
  output logic                 LANE_A1_DETECT
);

  logic [7:0]      eq_r;
  logic [7:0]      swing_r;
  logic [4:0]      deemph_r;
  logic [7:0]      idle_r;
  logic [7:0]      spare_r;
  logic [7:0]      sdet_r;
  logic [1:0]      rate_r;
  logic [1:0]      rate_nxt;
  logic            found_r;
  logic [7:0]      rdata_nxt;
  rlcr_lane_stat_s stat_meta_r;
  rlcr_lane_stat_s stat_r;
  logic [1:0]      auto_sync_r;
  logic            lane_a1_detect_nxt;

  wire logic       rate_auto;

  assign rate_auto = auto_sync_r[1];

  // status lines come from the analog side on no known clock: two flops each
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stat_meta_r <= '0;
      stat_r      <= '0;
      auto_sync_r <= 2'h0;
    end else begin
      stat_meta_r <= LANE_STAT;
      stat_r      <= stat_meta_r;
      auto_sync_r <= {auto_sync_r[0], RATE_PIN_AUTO};
    end
  end

  // host writes; the host owns swing bits 5:3, stored as written
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      eq_r     <= `RLCR_RST_EQ;
      swing_r  <= `RLCR_RST_SWING;
      deemph_r <= `RLCR_RST_DEEMPH;
      idle_r   <= `RLCR_RST_IDLE;
      spare_r  <= `RLCR_RST_SPARE;
      sdet_r   <= `RLCR_RST_SDET;
    end else if (REG_WR) begin
      if (REG_ADDR == `RLCR_OFS_EQ) begin
        eq_r <= REG_WDATA;
      end else if (REG_ADDR == `RLCR_OFS_SWING) begin
        swing_r <= REG_WDATA;
      end else if (REG_ADDR == `RLCR_OFS_DEEMPH) begin
        deemph_r <= REG_WDATA[`RLCR_DEEMPH_WMSB:0];
      end else if (REG_ADDR == `RLCR_OFS_IDLE) begin
        idle_r <= REG_WDATA;
      end else if (REG_ADDR == `RLCR_OFS_SPARE) begin
        spare_r <= REG_WDATA;
      end else if (REG_ADDR == `RLCR_OFS_SDET) begin
        sdet_r <= REG_WDATA;
      end
    end
  end

  // rate report only meaningful while the pin is strapped to automatic
  always_comb begin
    rate_nxt = `RLCR_RATE_NONE;
    if (rate_auto) begin
      rate_nxt = stat_r.detected_rate;
    end
  end

  // read-only status bits of the de-emphasis register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rate_r  <= `RLCR_RATE_NONE;
      found_r <= 1'b0;
    end else begin
      rate_r  <= rate_nxt;
      found_r <= stat_r.far_receiver_found;
    end
  end

  // force off wins over force on when both are set
  always_comb begin
    lane_a1_detect_nxt = stat_r.lane_a1_raw_detect;
    if (sdet_r[`RLCR_BIT_FORCE_OFF]) begin
      lane_a1_detect_nxt = 1'b0;
    end else if (sdet_r[`RLCR_BIT_FORCE_ON]) begin
      lane_a1_detect_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      LANE_A1_DETECT <= 1'b0;
    end else begin
      LANE_A1_DETECT <= lane_a1_detect_nxt;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = `RLCR_RDATA_NONE;
    if (REG_ADDR == `RLCR_OFS_EQ) begin
      rdata_nxt = eq_r;
    end else if (REG_ADDR == `RLCR_OFS_SWING) begin
      rdata_nxt = swing_r;
    end else if (REG_ADDR == `RLCR_OFS_DEEMPH) begin
      rdata_nxt = {found_r, rate_r, deemph_r};
    end else if (REG_ADDR == `RLCR_OFS_IDLE) begin
      rdata_nxt = idle_r;
    end else if (REG_ADDR == `RLCR_OFS_SPARE) begin
      rdata_nxt = spare_r;
    end else if (REG_ADDR == `RLCR_OFS_SDET) begin
      rdata_nxt = sdet_r;
    end
  end

  // read answer one cycle after the strobe, held until the next read
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA  <= `RLCR_RDATA_NONE;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_nxt;
      end
    end
  end

  // lane settings are wired straight from the register flops, so a write lands next edge
  // one process drives the whole struct, so the output variable keeps a single driver
  always_comb begin
    LANE_CTRL.input_equalizer_level = eq_r;
    LANE_CTRL.short_protect_en      = swing_r[`RLCR_BIT_SCP];
    LANE_CTRL.rate_class_low        = swing_r[`RLCR_BIT_RATE_SEL];
    LANE_CTRL.swing_spare           = swing_r[5:3];
    LANE_CTRL.output_swing_code     = swing_r[2:0];
    LANE_CTRL.deemphasis_code       = deemph_r[2:0];
    LANE_CTRL.idle_assert_code      = idle_r[3:2];
    LANE_CTRL.idle_deassert_code    = idle_r[1:0];
  end

  // checks on the bank's own behaviour
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_write_to(logic [7:0] ofs);
    REG_WR && (REG_ADDR == ofs);
  endsequence

  sequence s_read_of(logic [7:0] ofs);
    REG_RD && !REG_WR && (REG_ADDR == ofs);
  endsequence

  a_eq_write: assert property (s_write_to(`RLCR_OFS_EQ) |=>
    LANE_CTRL.input_equalizer_level == $past(REG_WDATA))
    else $error("equalizer level did not follow write");

  a_swing_fields: assert property (s_write_to(`RLCR_OFS_SWING) |=>
    (LANE_CTRL.short_protect_en == $past(REG_WDATA[7])) &&
    (LANE_CTRL.rate_class_low == $past(REG_WDATA[6])) &&
    (LANE_CTRL.output_swing_code == $past(REG_WDATA[2:0])))
    else $error("swing fields did not follow write");

  a_deemph_write: assert property (s_write_to(`RLCR_OFS_DEEMPH) |=>
    LANE_CTRL.deemphasis_code == $past(REG_WDATA[2:0]))
    else $error("de-emphasis code did not follow write");

  a_idle_write: assert property (s_write_to(`RLCR_OFS_IDLE) |=>
    (LANE_CTRL.idle_assert_code == $past(REG_WDATA[3:2])) &&
    (LANE_CTRL.idle_deassert_code == $past(REG_WDATA[1:0])))
    else $error("idle thresholds did not follow write");

  a_rate_manual: assert property (!rate_auto |=> (rate_r == `RLCR_RATE_NONE))
    else $error("rate report moved while pin not automatic");

  a_rate_auto: assert property (rate_auto ##1 rate_auto |->
    rate_r == $past(stat_r.detected_rate))
    else $error("rate report did not track detector");

  a_status_read: assert property (s_read_of(`RLCR_OFS_DEEMPH) |=>
    REG_RVALID && (REG_RDATA[7] == $past(found_r)) && (REG_RDATA[6:5] == $past(rate_r)))
    else $error("status bits misreported");

  a_force_off: assert property (sdet_r[`RLCR_BIT_FORCE_OFF] ##1 sdet_r[`RLCR_BIT_FORCE_OFF] |->
    !LANE_A1_DETECT)
    else $error("detect not forced off");

  a_force_on: assert property ((sdet_r[2:1] == 2'h1) ##1 (sdet_r[2:1] == 2'h1) |->
    LANE_A1_DETECT)
    else $error("detect not forced on");

  a_unmapped_read: assert property (REG_RD && ((REG_ADDR < `RLCR_OFS_EQ) || (REG_ADDR > `RLCR_OFS_SDET)) |=>
    REG_RVALID && (REG_RDATA == `RLCR_RDATA_NONE))
    else $error("unmapped read not zero");

  // equalizer readback returns the stored level
  a_eq_readback: assert property (s_read_of(`RLCR_OFS_EQ) |=>
    REG_RVALID && (REG_RDATA == $past(eq_r)))
    else $error("equalizer readback wrong");

  // swing readback returns the whole stored byte, spare bits included
  a_swing_readback: assert property (s_read_of(`RLCR_OFS_SWING) |=>
    REG_RVALID && (REG_RDATA == $past(swing_r)))
    else $error("swing readback wrong");

  // the writable low part of the de-emphasis register reads back as stored
  a_deemph_readback: assert property (s_read_of(`RLCR_OFS_DEEMPH) |=>
    REG_RVALID && (REG_RDATA[4:0] == $past(deemph_r)))
    else $error("de-emphasis readback wrong");

  // idle threshold readback returns the stored byte
  a_idle_readback: assert property (s_read_of(`RLCR_OFS_IDLE) |=>
    REG_RVALID && (REG_RDATA == $past(idle_r)))
    else $error("idle readback wrong");

  // the spare byte is plain storage
  a_spare_readback: assert property (s_read_of(`RLCR_OFS_SPARE) |=>
    REG_RVALID && (REG_RDATA == $past(spare_r)))
    else $error("spare readback wrong");

  // signal-detect force bits read back as stored
  a_sdet_readback: assert property (s_read_of(`RLCR_OFS_SDET) |=>
    REG_RVALID && (REG_RDATA == $past(sdet_r)))
    else $error("signal detect readback wrong");

  // every read strobe gets its valid pulse on the next edge
  a_rvalid_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");

  // valid is a single pulse; no strobe means no answer
  a_rvalid_pulse: assert property (!REG_RD |=>
    !REG_RVALID)
    else $error("valid without read");

  // read data stands until the next read, so a slow host can still take it
  a_rdata_hold: assert property (!REG_RD |=>
    $stable(REG_RDATA))
    else $error("read data moved without read");

  // with no force bit set the detect output follows the synchronised raw level
  a_raw_follow: assert property ((sdet_r[2:1] == 2'h0) ##1 (sdet_r[2:1] == 2'h0) |->
    LANE_A1_DETECT == $past(stat_r.lane_a1_raw_detect))
    else $error("detect not following raw level");

  // lane settings move only on a host write
  a_ctrl_hold: assert property (!REG_WR |=>
    $stable(LANE_CTRL))
    else $error("lane settings moved without write");

  // writes outside the bank leave every lane setting alone
  a_unmapped_write: assert property (REG_WR && ((REG_ADDR < `RLCR_OFS_EQ) || (REG_ADDR > `RLCR_OFS_SDET)) |=>
    $stable(LANE_CTRL))
    else $error("unmapped write changed settings");

  // spare swing bits are stored exactly as the host wrote them
  a_swing_spare: assert property (s_write_to(`RLCR_OFS_SWING) |=>
    LANE_CTRL.swing_spare == $past(REG_WDATA[5:3]))
    else $error("swing spare bits not stored");

endmodule

`default_nettype wire

/* tb/rlcr_host_model.sv */
// host side model issuing register accesses on the strobe port
`timescale 1ns/1ps
`default_nettype none
`include "rlcr_map.svh"
module rlcr_host_model (
  input  wire logic       CLOCK,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_RVALID,
  output logic      [7:0] REG_ADDR,
  output logic            REG_WR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_RD
);
  // port idle from time zero
  initial begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_WDATA = 8'h00;
    REG_RD = 1'b0;
  end
  // one write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `RLCR_OFS_SWING) v[5:3] = 3'b101;
    @(posedge CLOCK);
    #1;
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(posedge CLOCK);
    #1;
    REG_WR = 1'b0;
    REG_WDATA = ~v; // stale data scrambled so nothing leans on it
  endtask
  // one read; data counts only when the valid pulse is there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    #1;
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge CLOCK);
    #1;
    REG_RD = 1'b0;
    d = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* tb/rlcr_lane_regs_tb.sv */
// self-checking bench for the lane configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "rlcr_map.svh"
module rlcr_lane_regs_tb
  import rlcr_pkg::*;
;
  logic            clock;
  logic            rst_n;
  logic [7:0]      reg_addr;
  logic            reg_wr;
  logic [7:0]      reg_wdata;
  logic            reg_rd;
  logic [7:0]      reg_rdata;
  logic            reg_rvalid;
  rlcr_lane_stat_s lane_stat;
  logic            rate_pin_auto;
  rlcr_lane_ctrl_s lane_ctrl;
  logic            lane_a1_detect;
  int              mismatches;
  int              compares;
  logic [7:0]      d;
  logic [7:0]      ofs [7];
  logic [7:0]      dflt [7];
  localparam logic [21:0] CTRL_DFLT = {8'h2F, 1'b1, 1'b0, 3'h5, 3'h5, 3'h2, 2'h0, 2'h0};

  rlcr_host_model h (.CLOCK(clock), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd));
  rlcr_lane_regs uut (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .LANE_STAT(lane_stat), .RATE_PIN_AUTO(rate_pin_auto), .LANE_CTRL(lane_ctrl), .LANE_A1_DETECT(lane_a1_detect));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // compare seen against expected, count both outcomes
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // status inputs change just after an edge, then settle through the synchroniser
  task automatic stat(input logic [3:0] s, input logic au);
    @(posedge clock);
    #1;
    lane_stat = s;
    rate_pin_auto = au;
    repeat (6) @(posedge clock);
    #1;
  endtask
  // hang guard, far beyond the roughly 150 cycles the tests need
  initial begin
    #200us;
    mismatches++;
    finish_test();
  end

  initial begin
    ofs = '{`RLCR_OFS_EQ, `RLCR_OFS_SWING, `RLCR_OFS_DEEMPH, `RLCR_OFS_IDLE, `RLCR_OFS_SPARE, `RLCR_OFS_SDET, 8'h40};
    dflt = '{8'h2F, 8'hAD, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    rst_n = 1'b0;
    lane_stat = 4'h0;
    rate_pin_auto = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("ctrl", lane_ctrl, CTRL_DFLT);
    for (int i = 0; i < 7; i++) begin
      h.rd(ofs[i], d);
      chk("reset read", d, dflt[i]);
    end
    h.wr(`RLCR_OFS_EQ, 8'hFF);
    chk("eq", lane_ctrl.input_equalizer_level, 8'hFF);
    h.wr(8'h40, 8'h00);
    chk("eq kept", lane_ctrl.input_equalizer_level, 8'hFF);
    h.rd(`RLCR_OFS_EQ, d);
    chk("eq read", d, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      h.wr(`RLCR_OFS_SWING, {~i[0], i[0], 3'h0, i[2:0]});
      chk("swing", {lane_ctrl.short_protect_en, lane_ctrl.rate_class_low, lane_ctrl.output_swing_code},
        {~i[0], i[0], i[2:0]});
      chk("swing spare", lane_ctrl.swing_spare, 3'h5);
      h.wr(`RLCR_OFS_DEEMPH, {5'h1C, i[2:0]});
      chk("deemph", lane_ctrl.deemphasis_code, i[2:0]);
      h.rd(`RLCR_OFS_DEEMPH, d);
      chk("deemph read", d, {5'h00, i[2:0]});
    end
    h.rd(`RLCR_OFS_SWING, d);
    chk("swing read", d, 8'h6F);
    for (int i = 0; i < 4; i++) begin
      h.wr(`RLCR_OFS_IDLE, {4'h0, i[1:0], ~i[1:0]});
      chk("idle", {lane_ctrl.idle_assert_code, lane_ctrl.idle_deassert_code}, {i[1:0], ~i[1:0]});
    end
    h.rd(`RLCR_OFS_IDLE, d);
    chk("idle read", d, 8'h0C);
    stat(4'hE, 1'b1);
    h.rd(`RLCR_OFS_DEEMPH, d);
    chk("status auto", d[7:5], 3'h7);
    stat(4'hA, 1'b1);
    h.rd(`RLCR_OFS_DEEMPH, d);
    chk("status gen2", d[7:5], 3'h5);
    stat(4'hE, 1'b0);
    h.rd(`RLCR_OFS_DEEMPH, d);
    chk("status pinned", d[7:5], 3'h4);
    stat(4'h1, 1'b0);
    chk("detect", lane_a1_detect, 1'b1);
    for (int i = 0; i < 4; i++) begin
      h.wr(`RLCR_OFS_SDET, {5'h00, i[1:0], 1'b0});
      repeat (2) @(posedge clock);
      #1;
      chk("forced detect", lane_a1_detect, !i[1]);
    end
    h.wr(`RLCR_OFS_SDET, 8'h02);
    stat(4'h0, 1'b0);
    chk("detect raw low", lane_a1_detect, 1'b1);
    h.wr(`RLCR_OFS_SDET, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    chk("detect released", lane_a1_detect, 1'b0);
    rst_n = 1'b0;
    #1;
    chk("ctrl mid reset", lane_ctrl, CTRL_DFLT);
    @(posedge clock);
    #1;
    rst_n = 1'b1;
    h.rd(`RLCR_OFS_SDET, d);
    chk("sdet after reset", d, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
